//--- rtl/wdc_timeout_counter.sv
// shared constants of the watchdog control block, and its timeout counter
// assumes one clock, asynchronous active-high reset, a same-clock count tick
`timescale 1ns/1ps

package wdc_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0]  OFS_CTRL      = 4'h0;
    localparam logic [3:0]  OFS_CLR       = 4'h4;
    localparam logic [3:0]  OFS_SET       = 4'h8;
    localparam logic [3:0]  OFS_INV       = 4'hC;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          KEY_LSB       = 16;
    localparam int          ON_BIT        = 15;
    localparam int          RUN_PS_LSB    = 8;
    localparam int          CLK_CH_LSB    = 6;
    localparam int          SLP_PS_LSB    = 1;
    localparam int          WIN_BIT       = 0;
    // ------------------------------------------------------------------
    // key, lane pattern and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RESTART_KEY   = 16'h5743;
    localparam logic [3:0]  KEY_LANES     = 4'hC;
    localparam logic        ON_RESET      = 1'h0;
    localparam logic [4:0]  PS_RESET      = 5'h00;
    localparam logic [1:0]  CLK_CH_RESET  = 2'h0;
    localparam logic        WIN_RESET     = 1'h0;
    // restart window opens for the last quarter of the period
    localparam int          WIN_OPEN_SHIFT = 2;
endpackage : wdc_pkg

// ----------------------------------------------------------------------
// timeout counter
// ----------------------------------------------------------------------
module wdc_timeout_counter #(
    parameter int unsigned BASE_COUNT = 1
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       run_i,
    input  wire logic       restart_i,
    input  wire logic       tick_i,
    input  wire logic [4:0] postscale_i,
    output logic            expired_o,
    output logic            early_o
);
    logic [63:0] cnt;
    logic [63:0] limit;

    // period is base count times two to the postscaler
    assign limit   = 64'(BASE_COUNT) << postscale_i;
    // restart before the window opens counts as early
    assign early_o = cnt < (limit - (limit >> wdc_pkg::WIN_OPEN_SHIFT));

    // count ticks, wrap and flag at the end of the period
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt       <= 64'h0;
            expired_o <= 1'b0;
        end else if (ce_i) begin
            expired_o <= 1'b0;
            if (!run_i || restart_i) begin
                cnt <= 64'h0;
            end else if (tick_i) begin
                if (cnt >= limit - 64'h1) begin
                    cnt       <= 64'h0;
                    expired_o <= 1'b1;
                end else begin
                    cnt <= cnt + 64'h1;
                end
            end
        end
    end
endmodule : wdc_timeout_counter

//--- rtl/wdc_watchdog_control.sv
// watchdog control register, configuration shadows and timeout handling
// assumes a plain register port with read data one cycle after the strobe,
// configuration bits and sleep state arriving from outside this clock
//
// Summary of operation
// - Key 0x5743 written as one 16-bit access to upper half restarts count.
// - Upper sixteen bits hold the write-only key; they read zero.
// - Bit 15 enables the watchdog; resets to zero; read and write.
// - Software enable counts only when configuration enable bit is zero.
// - Bits 12..8 load the run postscaler configuration on every reset.
// - Bits 7..6 load the run clock choice configuration on every reset.
// - Bits 5..1 load the sleep postscaler configuration on every reset.
// - Bit 0 enables windowed mode; loads from window configuration bit.
// - Bits 14..13 ignore writes and read zero.
// - Offsets 4, 8, 12 clear, set or toggle the written one-bits.
// - Configuration-loaded shadows ignore software writes.
// - Enabled watchdog resets the device unless periodically restarted.
// - In sleep the watchdog uses the sleep postscaler and wakes instead.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps

module wdc_watchdog_control #(
    parameter int unsigned BASE_COUNT = 1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wr_lanes_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic [4:0]  cfg_run_postscale_i,
    input  wire logic [1:0]  cfg_run_clock_choice_i,
    input  wire logic [4:0]  cfg_sleep_postscale_i,
    input  wire logic        cfg_window_disable_i,
    input  wire logic        cfg_watchdog_enable_i,
    input  wire logic        sleep_i,
    input  wire logic        wdt_tick_i,
    output logic             active_o,
    output logic             restart_o,
    output logic             device_reset_o,
    output logic             wake_o
);
    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    localparam int SW = 15;

    logic [SW-1:0] sync_a;
    logic [SW-1:0] sync_b;
    logic [4:0]    cfg_run_ps_s;
    logic [1:0]    cfg_clk_s;
    logic [4:0]    cfg_slp_ps_s;
    logic          cfg_win_s;
    logic          cfg_en_s;
    logic          sleep_s;

    // two stages for every outside level
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else if (ce_i) begin
            sync_a <= {sleep_i, cfg_watchdog_enable_i, cfg_window_disable_i,
                       cfg_sleep_postscale_i, cfg_run_clock_choice_i, cfg_run_postscale_i};
            sync_b <= sync_a;
        end
    end

    assign cfg_run_ps_s = sync_b[4:0];
    assign cfg_clk_s    = sync_b[6:5];
    assign cfg_slp_ps_s = sync_b[11:7];
    assign cfg_win_s    = sync_b[12];
    assign cfg_en_s     = sync_b[13];
    assign sleep_s      = sync_b[14];

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic       enable_bit;
    logic       window_mode_enable;
    logic [4:0] run_postscale_copy;
    logic [1:0] run_clock_choice_copy;
    logic [4:0] sleep_postscale_copy;
    logic       loaded;
    logic [1:0] load_wait;

    // decoded write strobes
    logic       wr_ctrl;
    logic       wr_clr;
    logic       wr_set;
    logic       wr_inv;
    logic       key_hit;
    logic [1:0] wmask;
    logic [1:0] wbits;
    logic [1:0] cur;
    logic [1:0] next_bits;

    assign wr_ctrl = wr_i && (addr_i == wdc_pkg::OFS_CTRL);
    assign wr_clr  = wr_i && (addr_i == wdc_pkg::OFS_CLR);
    assign wr_set  = wr_i && (addr_i == wdc_pkg::OFS_SET);
    assign wr_inv  = wr_i && (addr_i == wdc_pkg::OFS_INV);

    // exact key, upper half lanes only, base address only
    assign key_hit = wr_ctrl && (wr_lanes_i == wdc_pkg::KEY_LANES)
                     && (wdata_i[31:wdc_pkg::KEY_LSB] == wdc_pkg::RESTART_KEY);

    // only bit 15 and bit 0 are software writable, gated by their lanes
    assign wmask = {wr_lanes_i[1], wr_lanes_i[0]};
    assign wbits = {wdata_i[wdc_pkg::ON_BIT], wdata_i[wdc_pkg::WIN_BIT]} & wmask;
    assign cur   = {enable_bit, window_mode_enable};

    // plain, clear, set and invert forms of a write
    always_comb begin
        next_bits = cur;
        if (wr_ctrl) begin
            next_bits = (cur & ~wmask) | wbits;
        end else if (wr_clr) begin
            next_bits = cur & ~wbits;
        end else if (wr_set) begin
            next_bits = cur | wbits;
        end else if (wr_inv) begin
            next_bits = cur ^ wbits;
        end
    end

    // writable control bits
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            enable_bit         <= wdc_pkg::ON_RESET;
            window_mode_enable <= wdc_pkg::WIN_RESET;
        end else if (ce_i) begin
            if (!loaded) begin
                window_mode_enable <= cfg_win_s;
            end else begin
                window_mode_enable <= next_bits[0];
            end
            enable_bit <= next_bits[1];
        end
    end

    // shadows caught from configuration once after each reset release
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_postscale_copy    <= wdc_pkg::PS_RESET;
            run_clock_choice_copy <= wdc_pkg::CLK_CH_RESET;
            sleep_postscale_copy  <= wdc_pkg::PS_RESET;
            loaded                <= 1'b0;
            load_wait             <= 2'h0;
        end else if (ce_i) begin
            // two enabled edges fill both synchroniser stages before the load
            load_wait <= {load_wait[0], 1'b1};
            if (!loaded && load_wait[1]) begin
                run_postscale_copy    <= cfg_run_ps_s;
                run_clock_choice_copy <= cfg_clk_s;
                sleep_postscale_copy  <= cfg_slp_ps_s;
                loaded                <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // key lanes and unused bits read zero; aliases and holes read zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            rdata_o <= 32'h0000_0000;
            if (rd_i && addr_i == wdc_pkg::OFS_CTRL) begin
                rdata_o[wdc_pkg::ON_BIT]                       <= enable_bit;
                rdata_o[wdc_pkg::RUN_PS_LSB+4:wdc_pkg::RUN_PS_LSB] <= run_postscale_copy;
                rdata_o[wdc_pkg::CLK_CH_LSB+1:wdc_pkg::CLK_CH_LSB] <= run_clock_choice_copy;
                rdata_o[wdc_pkg::SLP_PS_LSB+4:wdc_pkg::SLP_PS_LSB] <= sleep_postscale_copy;
                rdata_o[wdc_pkg::WIN_BIT]                      <= window_mode_enable;
            end
        end
    end

    // ------------------------------------------------------------------
    // timeout handling
    // ------------------------------------------------------------------
    logic       run_now;
    logic       expired;
    logic       early;
    logic [4:0] active_ps;

    // configuration enable overrides the software bit
    assign run_now   = loaded && (cfg_en_s || enable_bit);
    assign active_ps = sleep_s ? sleep_postscale_copy : run_postscale_copy;

    wdc_timeout_counter #(
        .BASE_COUNT (BASE_COUNT)
    ) u_counter (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .run_i       (run_now),
        .restart_i   (key_hit),
        .tick_i      (wdt_tick_i),
        .postscale_i (active_ps),
        .expired_o   (expired),
        .early_o     (early)
    );

    // status and event outputs, timeout resets in run and wakes in sleep
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_o       <= 1'b0;
            restart_o      <= 1'b0;
            device_reset_o <= 1'b0;
            wake_o         <= 1'b0;
        end else if (ce_i) begin
            active_o       <= run_now;
            restart_o      <= key_hit && run_now;
            device_reset_o <= run_now && ((expired && !sleep_s)
                              || (key_hit && window_mode_enable && early));
            wake_o         <= run_now && expired && sleep_s;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_key_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && key_hit && run_now) |=> restart_o)
        else $error("key write did not restart the watchdog");

    a_bad_key_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && wr_i && (wr_lanes_i != wdc_pkg::KEY_LANES
            || wdata_i[31:16] != wdc_pkg::RESTART_KEY)) |=> !restart_o)
        else $error("bad key or width restarted the watchdog");

    a_key_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && rd_i) |=> (rdata_o[31:16] == 16'h0000) && (rdata_o[14:13] == 2'h0))
        else $error("key or unused bits read nonzero");

    a_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && wr_ctrl && wr_lanes_i[1]) |=> enable_bit == $past(wdata_i[15]))
        else $error("enable bit did not take written value");

    a_cfg_governs: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && loaded && cfg_en_s) |=> active_o)
        else $error("configuration enable did not run watchdog");

    a_shadow_load: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !loaded && load_wait[1]) |=> run_postscale_copy == $past(cfg_run_ps_s)
            && run_clock_choice_copy == $past(cfg_clk_s)
            && sleep_postscale_copy == $past(cfg_slp_ps_s))
        else $error("shadow copies not loaded from configuration");

    a_shadow_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (loaded && wr_i) |=> $stable(run_postscale_copy) && $stable(sleep_postscale_copy)
            && $stable(run_clock_choice_copy))
        else $error("software write changed a shadow copy");

    a_alias_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && loaded && wr_set && wr_lanes_i[0] && wdata_i[0]) |=> window_mode_enable)
        else $error("set alias did not set window bit");

    a_alias_inv: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && wr_inv && wr_lanes_i[1] && wdata_i[15]) |=> enable_bit != $past(enable_bit))
        else $error("invert alias did not toggle enable");

    a_timeout_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && run_now && expired && !sleep_s) |=> device_reset_o && !wake_o)
        else $error("timeout in run mode gave no reset");

    a_sleep_wake: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && run_now && expired && sleep_s) |=> wake_o && !device_reset_o)
        else $error("timeout in sleep gave no wake");

    // ------------------------------------------------------------------
    // read path, alias, hole write and window load assertions
    // ------------------------------------------------------------------
    a_read_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !rd_i) |=> rdata_o == 32'h0000_0000)
        else $error("read data nonzero without a read");

    a_alias_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && rd_i && addr_i != wdc_pkg::OFS_CTRL) |=> rdata_o == 32'h0000_0000)
        else $error("alias or unmapped read returned data");

    a_read_fields: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && rd_i && addr_i == wdc_pkg::OFS_CTRL) |=> rdata_o[15] == $past(enable_bit)
            && rdata_o[12:8] == $past(run_postscale_copy)
            && rdata_o[7:6] == $past(run_clock_choice_copy)
            && rdata_o[5:1] == $past(sleep_postscale_copy)
            && rdata_o[0] == $past(window_mode_enable))
        else $error("control read did not return register fields");

    a_hole_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && loaded && wr_i && !wr_ctrl && !wr_clr && !wr_set && !wr_inv)
            |=> $stable(enable_bit) && $stable(window_mode_enable))
        else $error("unmapped write changed a control bit");

    a_alias_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && wr_clr && wr_lanes_i[1] && wdata_i[15]) |=> !enable_bit)
        else $error("clear alias did not clear enable");

    a_inv_window: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && loaded && wr_inv && wr_lanes_i[0] && wdata_i[0])
            |=> window_mode_enable != $past(window_mode_enable))
        else $error("invert alias did not toggle window bit");

    a_window_load: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !loaded) |=> window_mode_enable == $past(cfg_win_s))
        else $error("window bit not loaded from configuration");

    // ------------------------------------------------------------------
    // enable, window and event assertions
    // ------------------------------------------------------------------
    a_sw_enable_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && loaded && !cfg_en_s && !enable_bit) |=> !active_o)
        else $error("watchdog ran with both enables off");

    a_sw_enable_run: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && loaded && enable_bit) |=> active_o)
        else $error("software enable did not run watchdog");

    a_stopped_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !run_now) |=> !device_reset_o && !wake_o && !restart_o)
        else $error("stopped watchdog raised an event");

    a_window_early: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && run_now && key_hit && window_mode_enable && early) |=> device_reset_o)
        else $error("early key in window mode gave no reset");

    a_window_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !window_mode_enable && !expired) |=> !device_reset_o)
        else $error("reset without timeout while window mode off");

    a_wake_sleep_only: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !sleep_s) |=> !wake_o)
        else $error("wake raised outside sleep");

    a_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ce_i) |=> $stable(enable_bit) && $stable(window_mode_enable) && $stable(rdata_o))
        else $error("state changed while clock enable low");

endmodule : wdc_watchdog_control

//--- tb/tb.sv
// testbench for the watchdog control block: register port, shadows, restart key and timeouts
// assumes the block keeps its own assertions and answers reads one cycle after the strobe
`timescale 1ns/1ps

module tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic [3:0]  addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic [3:0]  wr_lanes_i = 4'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic [4:0]  cfg_run_postscale_i = 5'h15;
    logic [1:0]  cfg_run_clock_choice_i = 2'h2;
    logic [4:0]  cfg_sleep_postscale_i = 5'h0A;
    logic        cfg_window_disable_i = 1'b1;
    logic        cfg_watchdog_enable_i = 1'b0;
    logic        sleep_i = 1'b0;
    logic        wdt_tick_i = 1'b0;
    logic        active_o;
    logic        restart_o;
    logic        device_reset_o;
    logic        wake_o;
    int          n_fail = 0;
    int          samples_checked = 0;
    logic [2:0]  seen;

    // ------------------------------------------------------------------
    // clock and design
    // ------------------------------------------------------------------
    // 125 MHz system clock
    always #4 clk_i = ~clk_i;

    wdc_watchdog_control #(.BASE_COUNT(1)) wdc_watchdog_control_i (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .ce_i                   (ce_i),
        .addr_i                 (addr_i),
        .wdata_i                (wdata_i),
        .wr_lanes_i             (wr_lanes_i),
        .wr_i                   (wr_i),
        .rd_i                   (rd_i),
        .rdata_o                (rdata_o),
        .cfg_run_postscale_i    (cfg_run_postscale_i),
        .cfg_run_clock_choice_i (cfg_run_clock_choice_i),
        .cfg_sleep_postscale_i  (cfg_sleep_postscale_i),
        .cfg_window_disable_i   (cfg_window_disable_i),
        .cfg_watchdog_enable_i  (cfg_watchdog_enable_i),
        .sleep_i                (sleep_i),
        .wdt_tick_i             (wdt_tick_i),
        .active_o               (active_o),
        .restart_o              (restart_o),
        .device_reset_o         (device_reset_o),
        .wake_o                 (wake_o)
    );

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    // compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // print counts and verdict, then stop
    task automatic conclude();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    // hold reset for 6 cycles, then let the shadows load
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : do_reset

    // one-cycle write strobe with address, lanes and data
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] l);
        @(posedge clk_i);
        addr_i     <= a;
        wdata_i    <= d;
        wr_lanes_i <= l;
        wr_i       <= 1'b1;
        @(posedge clk_i);
        wr_i       <= 1'b0;
    endtask : wr

    // one-cycle read strobe; data is taken in the following cycle
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd

    // collect pulses {wake, device reset, restart} over n cycles
    task automatic watch(input int n, output logic [2:0] s);
        s = 3'b000;
        for (int i = 0; i < n; i++) begin
            #1;
            s = s | {wake_o, device_reset_o, restart_o};
            @(posedge clk_i);
        end
    endtask : watch

    // one watchdog clock tick
    task automatic tick();
        @(posedge clk_i);
        wdt_tick_i <= 1'b1;
        @(posedge clk_i);
        wdt_tick_i <= 1'b0;
    endtask : tick

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        do_reset();
        rd(wdc_pkg::OFS_CTRL, 32'h0000_1595);
        chk({31'h0, active_o}, 32'h0);
        // writes to key, unimplemented and shadow bits leave them alone
        wr(wdc_pkg::OFS_CTRL, 32'hFFFF_FFFF, 4'hF);
        rd(wdc_pkg::OFS_CTRL, 32'h0000_9595);
        repeat (4) @(posedge clk_i);
        chk({31'h0, active_o}, 32'h1);
        // clear, set and toggle aliases
        wr(wdc_pkg::OFS_CLR, 32'h0000_8001, 4'hF);
        rd(wdc_pkg::OFS_CTRL, 32'h0000_1594);
        wr(wdc_pkg::OFS_SET, 32'h0000_8001, 4'hF);
        rd(wdc_pkg::OFS_CTRL, 32'h0000_9595);
        wr(wdc_pkg::OFS_INV, 32'h0000_8001, 4'hF);
        rd(wdc_pkg::OFS_CTRL, 32'h0000_1594);
        wr(wdc_pkg::OFS_INV, 32'h0000_8000, 4'hF);
        rd(wdc_pkg::OFS_CTRL, 32'h0000_9594);
        rd(wdc_pkg::OFS_CLR, 32'h0);
        rd(wdc_pkg::OFS_SET, 32'h0);
        rd(wdc_pkg::OFS_INV, 32'h0);
        rd(4'h2, 32'h0);
        wr(4'h2, 32'hFFFF_FFFF, 4'hF);
        rd(wdc_pkg::OFS_CTRL, 32'h0000_9594);
        // second reset with other configuration, hardware enable on
        @(posedge clk_i);
        cfg_run_postscale_i    <= 5'h02;
        cfg_run_clock_choice_i <= 2'h1;
        cfg_sleep_postscale_i  <= 5'h01;
        cfg_window_disable_i   <= 1'b0;
        cfg_watchdog_enable_i  <= 1'b1;
        do_reset();
        rd(wdc_pkg::OFS_CTRL, 32'h0000_0242);
        chk({31'h0, active_o}, 32'h1);
        // restart key: right value and width, then wrong ones
        wr(wdc_pkg::OFS_CTRL, {wdc_pkg::RESTART_KEY, 16'h0}, 4'hC);
        watch(2, seen);
        chk({29'h0, seen}, 32'h1);
        wr(wdc_pkg::OFS_CTRL, 32'h5742_0000, 4'hC);
        watch(3, seen);
        chk({29'h0, seen}, 32'h0);
        wr(wdc_pkg::OFS_CTRL, {wdc_pkg::RESTART_KEY, 16'h0}, 4'hE);
        watch(3, seen);
        chk({29'h0, seen}, 32'h0);
        wr(wdc_pkg::OFS_CTRL, {wdc_pkg::RESTART_KEY, 16'h0}, 4'h8);
        watch(3, seen);
        chk({29'h0, seen}, 32'h0);
        // run timeout: period 1 << 2 = 4 ticks
        repeat (3) tick();
        watch(4, seen);
        chk({29'h0, seen}, 32'h0);
        tick();
        watch(3, seen);
        chk({29'h0, seen}, 32'h2);
        // sleep timeout: period 1 << 1 = 2 ticks, wakes instead of reset
        sleep_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        wr(wdc_pkg::OFS_CTRL, {wdc_pkg::RESTART_KEY, 16'h0}, 4'hC);
        watch(2, seen);
        tick();
        watch(4, seen);
        chk({29'h0, seen}, 32'h0);
        tick();
        watch(3, seen);
        chk({29'h0, seen}, 32'h4);
        sleep_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        // window mode: a key right after a restart is too early
        wr(wdc_pkg::OFS_CTRL, {wdc_pkg::RESTART_KEY, 16'h0}, 4'hC);
        watch(2, seen);
        wr(wdc_pkg::OFS_SET, 32'h0000_0001, 4'hF);
        rd(wdc_pkg::OFS_CTRL, 32'h0000_0243);
        wr(wdc_pkg::OFS_CTRL, {wdc_pkg::RESTART_KEY, 16'h0}, 4'hC);
        watch(3, seen);
        chk({29'h0, seen & 3'b110}, 32'h2);
        // clock enable low: a write in that cycle is ignored
        ce_i <= 1'b0;
        wr(wdc_pkg::OFS_SET, 32'h0000_8000, 4'hF);
        ce_i <= 1'b1;
        rd(wdc_pkg::OFS_CTRL, 32'h0000_0243);
        conclude();
    end
endmodule : tb
